// >>> src/cfd_defs.vh
`ifndef CFD_DEFS_VH
`define CFD_DEFS_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define CFD_OFS_CTRL      12'h020
`define CFD_OFS_STAT      12'h024
`define CFD_OFS_TDC       12'h028
`define CFD_OFS_DBT       12'h02C
`define CFD_OFS_TMI0      12'h180
`define CFD_OFS_TMI1      12'h190
`define CFD_OFS_TMI2      12'h1A0

// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define CFD_RST_CTRL      32'h00000000
`define CFD_RST_TDC       32'h00000000
`define CFD_RST_DBT       32'h01230000
`define CFD_RST_TMI       32'h00000000

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define CFD_CTRL_FD_ON    0
`define CFD_CTRL_EXDIS    2
`define CFD_CTRL_NON_ISO  3
`define CFD_CTRL_TDC_ON   4
`define CFD_CTRL_TDC_MODE 5
`define CFD_CTRL_ESI_MODE 6
`define CFD_CTRL_MASK     32'h0000007D
`define CFD_STAT_EXFLAG   16
`define CFD_TDC_MASK      32'h00007F7F
`define CFD_DBT_MASK      32'h037F03FF
`define CFD_TMI_REQ       0
`define CFD_TMI_KIND      1
`define CFD_TMI_FMT       2

// -----------------------------------------------------------------
// counts and limits
// -----------------------------------------------------------------
`define CFD_PASSIVE_LIMIT 8'h7F
`define CFD_TDC_MAX       7'h7F

`endif

// >>> src/cfd_phase_ctrl.v
// Functional notes
// - mode 0: ESI shows node error state
// - mode 1: mailbox ESI unless error passive
// - compensation mode: measure plus offset, or offset
// - compensation works only while enabled
// - exception: idle, or form error if disabled
// - FD behaviour only while FD enabled
// - exception flag status bit 16, write-one clears
// - current compensation value readable at bits 6:0
// - offset bits 14:8 added to measured delay
// - filter rejects too early receive edges
// - filter applies only when above current value
// - data jump width is field plus one
// - data segment two is field plus one
// - data segment one is field plus one
// - data divider sets data quantum prescaler
// - identifier word holds standard or extended id
// - bit 2 id format, bit 1 frame kind
// - transmit request set by software, hardware clears
// - mailbox ESI 0 dominant, 1 recessive
// - rate switch moves data phase to data rate
// - error passive when either count above 127
`timescale 1ns/1ps
`include "cfd_defs.vh"

module cfd_phase_ctrl (
	input  wire        mclk,
	input  wire        rst_n,
	input  wire [11:0] paddr,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire [7:0]  transmitErrorCount,
	input  wire [7:0]  receiveErrorCount,
	input  wire        protocolException,
	input  wire [2:0]  mailboxEmpty,
	input  wire [1:0]  activeMailbox,
	input  wire [2:0]  mailboxEsi,
	input  wire        rateSwitchSelect,
	input  wire        dataPhase,
	input  wire        dataHardSync,
	input  wire        engineTxBit,
	input  wire        tdcArm,
	input  wire        busReceivePin,
	output wire        busTransmitPin,
	output wire        fdOperationEnable,
	output wire        nonIsoSelect,
	output wire        errorPassive,
	output wire        esiRecessive,
	output reg         exceptionToIdle,
	output reg         exceptionFormError,
	output wire [6:0]  sspDelay,
	output wire [2:0]  dataSjwTq,
	output wire        dataRateActive,
	output reg         dataTqPulse,
	output reg         dataSamplePoint,
	output reg         dataBitEnd,
	output wire [2:0]  transmitRequest,
	output wire [31:0] txId0,
	output wire [31:0] txId1,
	output wire [31:0] txId2
);

	// -----------------------------------------------------------------
	// measurement states
	// -----------------------------------------------------------------
	localparam [1:0] TDC_IDLE  = 2'd0;
	localparam [1:0] TDC_WAIT  = 2'd1;
	localparam [1:0] TDC_COUNT = 2'd2;

	// -----------------------------------------------------------------
	// register storage
	// -----------------------------------------------------------------
	reg  [31:0] fdControl_reg;            // enables and modes
	reg         exceptionFlag_reg;        // sticky exception event
	reg  [31:0] delayComp_reg;            // offset and filter
	reg  [31:0] dataBitTiming_reg;        // data phase timing fields
	reg  [31:0] txIdent_reg [0:2];        // mailbox identifier words
	reg  [6:0]  delayCompValue_reg;       // value in use
	reg  [6:0]  delayCompValue_next;
	reg  [6:0]  measured_reg;             // last accepted loop delay
	reg  [6:0]  tdcCount_reg;             // running loop-delay count
	reg  [1:0]  tdcState_reg;
	reg         txPin_reg;                // registered transmit pin
	reg         rxMeta_reg;               // synchroniser first stage
	reg         rxSync_reg;               // synchroniser second stage
	reg         rxPrev_reg;               // for edge detection
	reg  [9:0]  prescale_reg;             // clocks within a quantum
	reg  [5:0]  tqIndex_reg;              // quantum within a bit

	// -----------------------------------------------------------------
	// field views
	// -----------------------------------------------------------------
	wire        fdEnable    = fdControl_reg[`CFD_CTRL_FD_ON];
	wire        exDisable   = fdControl_reg[`CFD_CTRL_EXDIS];
	wire        tdcEnable   = fdControl_reg[`CFD_CTRL_TDC_ON];
	wire        tdcOffsOnly = fdControl_reg[`CFD_CTRL_TDC_MODE];
	wire        esiMode     = fdControl_reg[`CFD_CTRL_ESI_MODE];
	wire [6:0]  tdcOffset   = delayComp_reg[14:8];
	wire [6:0]  tdcFilter   = delayComp_reg[6:0];
	wire [1:0]  dataSjw     = dataBitTiming_reg[25:24];
	wire [2:0]  dataSeg2    = dataBitTiming_reg[22:20];
	wire [3:0]  dataSeg1    = dataBitTiming_reg[19:16];
	wire [9:0]  dataDivider = dataBitTiming_reg[9:0];

	// -----------------------------------------------------------------
	// apb decode
	// -----------------------------------------------------------------
	// slave answers in the access cycle, no wait states
	wire        apbWrite  = psel & penable & pwrite;
	wire        hitCtrl   = (paddr == `CFD_OFS_CTRL);
	wire        hitStat   = (paddr == `CFD_OFS_STAT);
	wire        hitTdc    = (paddr == `CFD_OFS_TDC);
	wire        hitDbt    = (paddr == `CFD_OFS_DBT);
	wire [2:0]  hitTmi;
	wire        hitAny    = hitCtrl | hitStat | hitTdc | hitDbt | (|hitTmi);

	assign hitTmi[0] = (paddr == `CFD_OFS_TMI0);
	assign hitTmi[1] = (paddr == `CFD_OFS_TMI1);
	assign hitTmi[2] = (paddr == `CFD_OFS_TMI2);
	assign pready    = 1'b1;
	// unmapped addresses answer with an error, reads return zero
	assign pslverr   = psel & penable & ~hitAny;

	// -----------------------------------------------------------------
	// read mux
	// -----------------------------------------------------------------
	// byte lanes are not decoded: partial writes cannot exist on this bus
	// so software must always move whole words
	always @* begin
		prdata = 32'h00000000;
		if (hitCtrl) begin
			prdata = fdControl_reg;
		end else if (hitStat) begin
			// flag and current value, rest reads zero
			prdata = {15'h0000, exceptionFlag_reg, 9'h000, delayCompValue_reg};
		end else if (hitTdc) begin
			prdata = delayComp_reg;
		end else if (hitDbt) begin
			prdata = dataBitTiming_reg;
		end else if (hitTmi[0]) begin
			prdata = txIdent_reg[0];
		end else if (hitTmi[1]) begin
			prdata = txIdent_reg[1];
		end else if (hitTmi[2]) begin
			prdata = txIdent_reg[2];
		end
	end

	// -----------------------------------------------------------------
	// configuration registers
	// -----------------------------------------------------------------
	// reserved bits are masked so they always read as zero
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fdControl_reg     <= `CFD_RST_CTRL;
			delayComp_reg     <= `CFD_RST_TDC;
			dataBitTiming_reg <= `CFD_RST_DBT;
		end else if (apbWrite) begin
			if (hitCtrl) begin
				fdControl_reg <= pwdata & `CFD_CTRL_MASK;
			end
			if (hitTdc) begin
				delayComp_reg <= pwdata & `CFD_TDC_MASK;
			end
			if (hitDbt) begin
				dataBitTiming_reg <= pwdata & `CFD_DBT_MASK;
			end
		end
	end

	// -----------------------------------------------------------------
	// exception flag and response
	// -----------------------------------------------------------------
	// a new event in the clearing cycle keeps the flag set
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			exceptionFlag_reg  <= 1'b0;
			exceptionToIdle    <= 1'b0;
			exceptionFormError <= 1'b0;
		end else begin
			// detection enabled: flag it and send the controller idle
			exceptionToIdle    <= protocolException & fdEnable & ~exDisable;
			// detection disabled: handled as an ordinary form error
			exceptionFormError <= protocolException & fdEnable & exDisable;
			if (protocolException & fdEnable & ~exDisable) begin
				exceptionFlag_reg <= 1'b1;
			end else if (apbWrite & hitStat & pwdata[`CFD_STAT_EXFLAG]) begin
				exceptionFlag_reg <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------
	// transmit mailbox identifiers
	// -----------------------------------------------------------------
	// one word per mailbox; request bit set by software wins over the
	// hardware clear arriving in the same cycle
	genvar mb;
	generate
		for (mb = 0; mb < 3; mb = mb + 1) begin : gMailbox
			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					txIdent_reg[mb] <= `CFD_RST_TMI;
				end else if (apbWrite & hitTmi[mb]) begin
					// id, format, kind and request all from software
					txIdent_reg[mb] <= pwdata;
					if (!pwdata[`CFD_TMI_REQ] & mailboxEmpty[mb]) begin
						txIdent_reg[mb][`CFD_TMI_REQ] <= 1'b0;
					end
				end else if (mailboxEmpty[mb]) begin
					// frame gone, mailbox empty again
					txIdent_reg[mb][`CFD_TMI_REQ] <= 1'b0;
				end
			end
			assign transmitRequest[mb] = txIdent_reg[mb][`CFD_TMI_REQ];
		end
	endgenerate

	// identifier words go to the engine whole; bits 31:21 standard id,
	// 31:3 extended id, bit 2 format, bit 1 kind
	assign txId0 = txIdent_reg[0];
	assign txId1 = txIdent_reg[1];
	assign txId2 = txIdent_reg[2];

	// -----------------------------------------------------------------
	// error state indicator
	// -----------------------------------------------------------------
	assign errorPassive = (transmitErrorCount > `CFD_PASSIVE_LIMIT) |
	                      (receiveErrorCount > `CFD_PASSIVE_LIMIT);

	// passive nodes always send recessive; active nodes send dominant in
	// mode 0, or the mailbox setting in mode 1 (1 means recessive)
	assign esiRecessive = errorPassive ? 1'b1 :
	                      (esiMode ? mailboxEsi[activeMailbox] : 1'b0);

	assign fdOperationEnable = fdEnable;
	assign nonIsoSelect      = fdControl_reg[`CFD_CTRL_NON_ISO];

	// -----------------------------------------------------------------
	// pin registers and receive synchroniser
	// -----------------------------------------------------------------
	// the receive pin is asynchronous; only the second stage is used
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txPin_reg  <= 1'b1;
			rxMeta_reg <= 1'b1;
			rxSync_reg <= 1'b1;
			rxPrev_reg <= 1'b1;
		end else begin
			txPin_reg  <= engineTxBit;
			rxMeta_reg <= busReceivePin;
			rxSync_reg <= rxMeta_reg;
			rxPrev_reg <= rxSync_reg;
		end
	end

	assign busTransmitPin = txPin_reg;

	wire txFall = txPin_reg & ~engineTxBit;   // pin goes dominant next edge
	wire rxFall = rxPrev_reg & ~rxSync_reg;   // dominant edge seen back
	// filter only counts when set above the value in use
	wire filterOn = (tdcFilter > delayCompValue_reg);
	wire tooEarly = filterOn & (tdcCount_reg < tdcFilter);

	// -----------------------------------------------------------------
	// loop delay measurement
	// -----------------------------------------------------------------
	// counts clocks from a dominant transmit edge to its echo; the count
	// includes the two synchroniser clocks, which the offset absorbs
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tdcState_reg <= TDC_IDLE;
			tdcCount_reg <= 7'h00;
			measured_reg <= 7'h00;
		end else begin
			case (tdcState_reg)
				TDC_IDLE: begin
					// armed only when enabled and measuring
					if (tdcArm & tdcEnable & ~tdcOffsOnly & fdEnable) begin
						tdcState_reg <= TDC_WAIT;
					end
				end
				TDC_WAIT: begin
					if (!tdcEnable) begin
						tdcState_reg <= TDC_IDLE;
					end else if (txFall) begin
						tdcState_reg <= TDC_COUNT;
						tdcCount_reg <= 7'h00;
					end
				end
				TDC_COUNT: begin
					if (!tdcEnable) begin
						tdcState_reg <= TDC_IDLE;
					end else if (rxFall & ~tooEarly) begin
						// accepted edge closes the measurement
						measured_reg <= tdcCount_reg;
						tdcState_reg <= TDC_IDLE;
					end else if (tdcCount_reg != `CFD_TDC_MAX) begin
						// saturates rather than wrap to a short delay
						tdcCount_reg <= tdcCount_reg + 7'h01;
					end
				end
				default: begin
					tdcState_reg <= TDC_IDLE;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// compensation value in use
	// -----------------------------------------------------------------
	wire [7:0] delaySum = {1'b0, measured_reg} + {1'b0, tdcOffset};

	always @* begin
		delayCompValue_next = 7'h00;
		if (tdcEnable & fdEnable) begin
			if (tdcOffsOnly) begin
				delayCompValue_next = tdcOffset;
			end else if (delaySum[7]) begin
				delayCompValue_next = `CFD_TDC_MAX;
			end else begin
				delayCompValue_next = delaySum[6:0];
			end
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			delayCompValue_reg <= 7'h00;
		end else begin
			delayCompValue_reg <= delayCompValue_next;
		end
	end

	// secondary sample point position after the transmit edge, clocks
	assign sspDelay = delayCompValue_reg;

	// -----------------------------------------------------------------
	// data phase bit timing
	// -----------------------------------------------------------------
	// data rate only for switched FD frames inside the data phase
	assign dataRateActive = fdEnable & rateSwitchSelect & dataPhase;
	assign dataSjwTq      = {1'b0, dataSjw} + 3'd1;

	wire       tqDone   = (prescale_reg == dataDivider);
	wire [5:0] seg1End  = {2'b00, dataSeg1} + 6'd1;
	wire [5:0] bitLast  = seg1End + {3'b000, dataSeg2} + 6'd1;

	// sync quantum is index 0, segment one ends at index seg1+1, segment
	// two ends at seg1+seg2+2; hard sync restarts the bit at sync
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prescale_reg    <= 10'h000;
			tqIndex_reg     <= 6'h00;
			dataTqPulse     <= 1'b0;
			dataSamplePoint <= 1'b0;
			dataBitEnd      <= 1'b0;
		end else if (!dataRateActive | dataHardSync) begin
			prescale_reg    <= 10'h000;
			tqIndex_reg     <= 6'h00;
			dataTqPulse     <= 1'b0;
			dataSamplePoint <= 1'b0;
			dataBitEnd      <= 1'b0;
		end else begin
			dataTqPulse     <= tqDone;
			dataSamplePoint <= tqDone & (tqIndex_reg == seg1End);
			dataBitEnd      <= tqDone & (tqIndex_reg == bitLast);
			if (tqDone) begin
				prescale_reg <= 10'h000;
				if (tqIndex_reg == bitLast) begin
					tqIndex_reg <= 6'h00;
				end else begin
					tqIndex_reg <= tqIndex_reg + 6'h01;
				end
			end else begin
				prescale_reg <= prescale_reg + 10'h001;
			end
		end
	end

endmodule // cfd_phase_ctrl

// >>> testbench/cfd_bus_node.sv
`timescale 1ns/1ps
// far nodes on the bus: our transmit level comes back after a loop delay
module cfd_bus_node (
	input  wire       mclk,
	input  wire       busTransmitPin,
	input  wire [4:0] loopDelay,
	output wire       busReceivePin
);
	// transmit history, newest in bit 0; idle bus is recessive
	reg [31:0] txHist_reg = 32'hFFFFFFFF;
	// shift every clock; delay is loopDelay plus one cycles
	always @(posedge mclk) begin
		txHist_reg <= {txHist_reg[30:0], busTransmitPin};
	end
	assign busReceivePin = txHist_reg[loopDelay];
endmodule // cfd_bus_node

// >>> testbench/cfd_phase_ctrl_sva.sv
`timescale 1ns/1ps
`include "cfd_defs.vh"
// port checker for the phase control block
module cfd_phase_ctrl_sva (
	input wire        mclk,
	input wire        rst_n,
	input wire [11:0] paddr,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] prdata,
	input wire [7:0]  transmitErrorCount,
	input wire [7:0]  receiveErrorCount,
	input wire        protocolException,
	input wire [2:0]  mailboxEmpty,
	input wire        rateSwitchSelect,
	input wire        dataPhase,
	input wire        fdOperationEnable,
	input wire        errorPassive,
	input wire        esiRecessive,
	input wire        exceptionToIdle,
	input wire        exceptionFormError,
	input wire [6:0]  sspDelay,
	input wire        dataRateActive,
	input wire        dataTqPulse,
	input wire [2:0]  transmitRequest
);
	// ------
	// helpers
	// ------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// write to mailbox 1 in its access cycle, the mailbox the bench uses
	wire wrMbox1 = psel && penable && pwrite && paddr == `CFD_OFS_TMI1;
	sequence excTaken;
		protocolException && fdOperationEnable;
	endsequence
	sequence rateIdle;
		!dataRateActive ##1 !dataRateActive;
	endsequence
	sequence statRead;
		psel && penable && !pwrite && paddr == `CFD_OFS_STAT;
	endsequence
	// ------
	// assertions
	// ------
	a_passive_limit: assert property (
		errorPassive == (transmitErrorCount > 8'h7F || receiveErrorCount > 8'h7F))
		else $error("passive flag disagrees with counts");
	a_passive_esi: assert property (errorPassive |-> esiRecessive)
		else $error("passive node sent dominant indicator");
	a_exc_answer: assert property (excTaken |=> exceptionToIdle ^ exceptionFormError)
		else $error("exception not answered by exactly one pulse");
	a_exc_cause: assert property (
		(exceptionToIdle || exceptionFormError) |->
		$past(protocolException) && $past(fdOperationEnable))
		else $error("exception pulse without cause");
	a_rate_gate: assert property (
		dataRateActive == (fdOperationEnable && rateSwitchSelect && dataPhase))
		else $error("data rate gating wrong");
	a_rate_idle: assert property (rateIdle |-> !dataTqPulse)
		else $error("quantum pulse while data rate idle");
	a_req_clear: assert property (
		mailboxEmpty[1] && !wrMbox1 |=> !transmitRequest[1])
		else $error("request kept after mailbox empty");
	a_req_hold: assert property (
		transmitRequest[1] && !mailboxEmpty[1] && !wrMbox1 |=> transmitRequest[1])
		else $error("request dropped without cause");
	a_stat_value: assert property (
		statRead |-> prdata[6:0] == sspDelay && prdata[15:7] == 9'h000)
		else $error("status value field wrong");
	a_fd_off_zero: assert property (
		!fdOperationEnable [*2] |-> sspDelay == 7'h00)
		else $error("compensation value while fd off");
endmodule // cfd_phase_ctrl_sva

bind cfd_phase_ctrl cfd_phase_ctrl_sva cfd_phase_ctrl_sva_i (.mclk, .rst_n, .paddr, .psel,
	.penable, .pwrite, .prdata, .transmitErrorCount, .receiveErrorCount, .protocolException,
	.mailboxEmpty, .rateSwitchSelect, .dataPhase, .fdOperationEnable, .errorPassive,
	.esiRecessive, .exceptionToIdle, .exceptionFormError, .sspDelay, .dataRateActive,
	.dataTqPulse, .transmitRequest);

// >>> testbench/cfd_phase_ctrl_tb.sv
`timescale 1ns/1ps
`include "cfd_defs.vh"
module cfd_phase_ctrl_tb;
	// ------
	// inputs, all set at time zero
	// ------
	reg        mclk = 1'b0;
	reg        rst_n = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg        psel = 1'b0;
	reg        penable = 1'b0;
	reg        pwrite = 1'b0;
	reg [31:0] pwdata = 32'h00000000;
	reg [7:0]  transmitErrorCount = 8'h00;
	reg [7:0]  receiveErrorCount = 8'h00;
	reg        protocolException = 1'b0;
	reg [2:0]  mailboxEmpty = 3'h0;
	reg [1:0]  activeMailbox = 2'h0;
	reg [2:0]  mailboxEsi = 3'h2;     // mailbox 1 recessive, others dominant
	reg        rateSwitchSelect = 1'b0;
	reg        dataPhase = 1'b0;
	reg        dataHardSync = 1'b0;   // pulsed once, by the hard sync check
	reg        engineTxBit = 1'b1;
	reg        tdcArm = 1'b0;
	reg [4:0]  loopDelay = 5'h01;
	// outputs
	wire [31:0] prdata, txId0, txId1, txId2;
	wire [6:0]  sspDelay;
	wire [2:0]  dataSjwTq, transmitRequest;
	wire        pready, pslverr, busReceivePin, busTransmitPin, fdOperationEnable;
	wire        nonIsoSelect, errorPassive, esiRecessive, exceptionToIdle, exceptionFormError;
	wire        dataRateActive, dataTqPulse, dataSamplePoint, dataBitEnd;
	// bookkeeping
	integer    fail_count = 0;
	integer    cmp_count = 0;
	integer    sp;
	integer    bt;
	reg [31:0] rd;
	reg [31:0] v2;
	reg [31:0] v8;
	reg        slvErr;

	always #20 mclk = ~mclk;

	cfd_phase_ctrl cfd_phase_ctrl_i (.mclk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .transmitErrorCount, .receiveErrorCount, .protocolException,
		.mailboxEmpty, .activeMailbox, .mailboxEsi, .rateSwitchSelect, .dataPhase, .dataHardSync,
		.engineTxBit, .tdcArm, .busReceivePin, .busTransmitPin, .fdOperationEnable, .nonIsoSelect,
		.errorPassive, .esiRecessive, .exceptionToIdle, .exceptionFormError, .sspDelay,
		.dataSjwTq, .dataRateActive, .dataTqPulse, .dataSamplePoint, .dataBitEnd,
		.transmitRequest, .txId0, .txId1, .txId2);
	cfd_bus_node cfd_bus_node_i (.mclk, .busTransmitPin, .loopDelay, .busReceivePin);

	// ------
	// tasks
	// ------
	task chk(input string what, input [31:0] seen, input [31:0] exp);
		begin
			cmp_count = cmp_count + 1;
			if (seen !== exp) begin
				fail_count = fail_count + 1;
				$display("wrong value %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task close_out;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fail_count);
			if (fail_count == 0 && cmp_count > 0) begin
				$display("== PASSED ==");
			end else begin
				$display("== FAILED ==");
			end
			$finish;
		end
	endtask
	task give_up;
		begin
			fail_count = fail_count + 1;
			close_out;
		end
	endtask
	// one whole-word transfer; waits for pready, no fixed latency assumed
	task apb(input wr, input [11:0] a, input [31:0] d);
		integer n;
		begin
			@(posedge mclk);
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= a;
			pwdata <= d;
			@(posedge mclk);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge mclk);
				n = n + 1;
			end while (pready !== 1'b1 && n < 50);
			if (pready !== 1'b1) give_up;
			rd = prdata;
			slvErr = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rdchk(input string what, input [11:0] a, input [31:0] exp);
		begin
			apb(1'b0, a, 32'h00000000);
			chk(what, rd, exp);
		end
	endtask
	task wrchk(input string what, input [11:0] a, input [31:0] d, input [31:0] exp);
		begin
			apb(1'b1, a, d);
			rdchk(what, a, exp);
		end
	endtask
	// one loop-delay measurement, then read the status word
	task tdc_run(input [4:0] dly);
		begin
			@(posedge mclk);
			loopDelay <= dly;
			tdcArm <= 1'b1;
			@(posedge mclk);
			tdcArm <= 1'b0;
			engineTxBit <= 1'b0;
			repeat (60) @(posedge mclk);
			engineTxBit <= 1'b1;
			// bus back to recessive before anything else
			repeat (20) @(posedge mclk);
			apb(1'b0, `CFD_OFS_STAT, 32'h00000000);
		end
	endtask
	task exc(input [1:0] e);
		begin
			@(posedge mclk);
			protocolException <= 1'b1;
			@(posedge mclk);
			protocolException <= 1'b0;
			@(negedge mclk);
			chk("exception", 32'({exceptionFormError, exceptionToIdle}), e);
		end
	endtask
	task esi(input [7:0] t, input [7:0] r, input [1:0] m, input [1:0] e);
		begin
			@(posedge mclk);
			transmitErrorCount <= t;
			receiveErrorCount <= r;
			activeMailbox <= m;
			@(negedge mclk);
			chk("esi", 32'({errorPassive, esiRecessive}), e);
		end
	endtask
	// bit length and sample point, counted from one bit end
	task dbt_run(input [31:0] w);
		integer n;
		begin
			apb(1'b1, `CFD_OFS_DBT, w);
			dataPhase <= 1'b1;
			sp = 0;
			bt = 0;
			n = 0;
			while (dataBitEnd !== 1'b1 && n < 900) begin
				@(negedge mclk);
				n = n + 1;
			end
			n = 0;
			while (bt == 0 && n < 900) begin
				@(negedge mclk);
				n = n + 1;
				if (dataSamplePoint === 1'b1) sp = n;
				if (dataBitEnd === 1'b1) bt = n;
			end
			if (bt == 0) give_up;
			@(posedge mclk);
			dataPhase <= 1'b0;
			chk("sjw", 32'(dataSjwTq), w[25:24] + 1);
			chk("sample", sp, (w[9:0] + 1) * (w[19:16] + 2));
			chk("bit", bt, (w[9:0] + 1) * (w[19:16] + w[22:20] + 3));
		end
	endtask

	// ------
	// main sequence
	// ------
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rdchk("control", `CFD_OFS_CTRL, 32'h00000000);
		rdchk("status", `CFD_OFS_STAT, 32'h00000000);
		rdchk("timing", `CFD_OFS_DBT, 32'h01230000);
		rdchk("mailbox0", `CFD_OFS_TMI0, 32'h00000000);
		chk("sjw", 32'(dataSjwTq), 32'h00000002);
		wrchk("timing", `CFD_OFS_DBT, 32'hFFFFFFFF, 32'h037F03FF);
		wrchk("delay", `CFD_OFS_TDC, 32'hFFFFFFFF, 32'h00007F7F);
		wrchk("control", `CFD_OFS_CTRL, 32'hFFFFFFFF, 32'h0000007D);
		chk("fd", 32'({fdOperationEnable, nonIsoSelect}), 32'h00000003);
		// only-offset mode shows the offset; status value field is read-only
		wrchk("status", `CFD_OFS_STAT, 32'hFFFFFFFF, 32'h0000007F);
		apb(1'b0, 12'h030, 32'h00000000);
		chk("slverr", 32'(slvErr), 32'h00000001);
		chk("unmapped", rd, 32'h00000000);
		// measured delay tracks the loop, then offset and filter
		apb(1'b1, `CFD_OFS_TDC, 32'h00000000);
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000011);
		tdc_run(5'h02);
		v2 = rd;
		tdc_run(5'h08);
		v8 = rd;
		chk("tdc step", v8 - v2, 32'h00000006);
		apb(1'b1, `CFD_OFS_TDC, 32'h00001400);
		tdc_run(5'h08);
		chk("tdc offset", rd, v8 + 32'h00000014);
		apb(1'b1, `CFD_OFS_TDC, v8 + 32'h0000001E);
		tdc_run(5'h02);
		chk("tdc filter", rd, v8);
		// a rejected echo leaves the count running; disabling ends it
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000001);
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000011);
		apb(1'b1, `CFD_OFS_TDC, v8);
		tdc_run(5'h02);
		chk("tdc nofilter", rd, v2);
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000001);
		rdchk("tdc off", `CFD_OFS_STAT, 32'h00000000);
		apb(1'b1, `CFD_OFS_TDC, 32'h00002200);
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000031);
		rdchk("tdc only", `CFD_OFS_STAT, 32'h00000022);
		// exceptions
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000001);
		exc(2'b01);
		rdchk("flag", `CFD_OFS_STAT, 32'h00010000);
		wrchk("flag clr", `CFD_OFS_STAT, 32'h00010000, 32'h00000000);
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000005);
		exc(2'b10);
		rdchk("flag off", `CFD_OFS_STAT, 32'h00000000);
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000000);
		exc(2'b00);
		// error state indicator
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000001);
		esi(8'h7F, 8'h00, 2'h1, 2'b00);
		esi(8'h80, 8'h00, 2'h1, 2'b11);
		esi(8'h00, 8'h80, 2'h1, 2'b11);
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000041);
		esi(8'h00, 8'h00, 2'h1, 2'b01);
		esi(8'h00, 8'h00, 2'h0, 2'b00);
		esi(8'hC8, 8'h00, 2'h0, 2'b11);
		// mailbox word and its request bit
		apb(1'b1, `CFD_OFS_TMI1, {29'h1ABCDEF1, 3'b111});
		// registered outputs settle after the write edge
		@(negedge mclk);
		chk("request", 32'(transmitRequest), 32'h00000002);
		chk("id word", txId1, {29'h1ABCDEF1, 3'b111});
		chk("other ids", txId0 | txId2, 32'h00000000);
		@(posedge mclk);
		mailboxEmpty <= 3'h2;
		@(posedge mclk);
		mailboxEmpty <= 3'h0;
		rdchk("mailbox1", `CFD_OFS_TMI1, {29'h1ABCDEF1, 3'b110});
		// data-phase bit timing
		apb(1'b1, `CFD_OFS_CTRL, 32'h00000001);
		rateSwitchSelect <= 1'b1;
		dbt_run(32'h02230002);
		dbt_run(32'h037F0000);
		// hard sync mid-bit restarts timing: next end one full bit later
		@(posedge mclk);
		dataPhase <= 1'b1;
		repeat (10) @(posedge mclk);
		dataHardSync <= 1'b1;
		@(posedge mclk);
		dataHardSync <= 1'b0;
		@(negedge mclk);
		bt = 0;
		while (dataBitEnd !== 1'b1 && bt < 900) begin
			@(negedge mclk);
			bt = bt + 1;
		end
		chk("hard sync", bt, 32'd25);
		close_out;
	end
endmodule // cfd_phase_ctrl_tb
